// *** common/ira_pkg.sv ***
// constants, carriers and address decoding for the indirect register access unit
// assumes a single 200 MHz clock and a plain strobed register port
package ira_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int SLOT_W = 6;
	localparam int SLOTS = 33;
	localparam int EVT_W = 3;

	// ----------------------------------------------------------------
	// direct register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h15;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h16;
	localparam logic [7:0] OFS_INDIRECT_DATA = 8'h1C;
	localparam logic [7:0] OFS_INDIRECT_ADDRESS = 8'h1D;
	localparam logic [7:0] OFS_ACCESS_STATUS = 8'h1F;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int EVT_DONE = 0;
	localparam int EVT_REFUSED = 1;
	localparam int EVT_UNMAPPED = 2;
	localparam int STS_PENDING = 0;
	localparam int STS_IS_WRITE = 1;
	localparam int STS_DATA_WRITTEN = 2;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [7:0] RST_ADDR = 8'h00;
	localparam logic [2:0] RST_EVT = 3'h0;
	localparam longint CLK_HZ = 200000000;
	localparam longint TICK_HZ = 16000;
	localparam int TICK_CYCLES = int'(CLK_HZ / TICK_HZ);

	// ----------------------------------------------------------------
	// indirect address map
	// ----------------------------------------------------------------
	localparam logic [7:0] IA_OSC_FIRST = 8'h00;
	localparam logic [7:0] IA_OSC_LAST = 8'h05;
	localparam logic [7:0] IA_RING_FIRST = 8'h06;
	localparam logic [7:0] IA_RING_LAST = 8'h09;
	localparam logic [7:0] IA_RECEIVE_GAIN = 8'h0D;
	localparam logic [7:0] IA_TRANSMIT_GAIN = 8'h0E;
	localparam logic [7:0] IA_LOOP_UPPER = 8'h0F;
	localparam logic [7:0] IA_LINE_LAST = 8'h1B;
	localparam logic [7:0] IA_MIN_VOLTAGE = 8'h40;
	localparam logic [7:0] IA_LOOP_LOWER = 8'h42;
	localparam logic [7:0] IA_FSK_FIRST = 8'h45;
	localparam logic [7:0] IA_FSK_LAST = 8'h4A;
	localparam logic [5:0] SLOT_GAIN_BASE = 6'h0A;
	localparam logic [5:0] SLOT_MIN_VOLTAGE = 6'h19;
	localparam logic [5:0] SLOT_LOOP_LOWER = 6'h1A;
	localparam logic [5:0] SLOT_FSK_BASE = 6'h1B;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ira_bus_req_type;

	typedef struct packed {
		logic mapped;
		logic [SLOT_W-1:0] slot;
	} ira_decode_type;

	// renumbered map: oscillator, ringing, gain and line words pack densely into slots
	function automatic ira_decode_type ira_decode(input logic [ADDR_W-1:0] a);
		ira_decode_type d;
		d.mapped = 1'b1;
		d.slot = '0;
		if (a <= IA_RING_LAST)
			d.slot = a[SLOT_W-1:0];
		else if (a >= IA_RECEIVE_GAIN && a <= IA_LINE_LAST)
			d.slot = SLOT_W'(a - IA_RECEIVE_GAIN) + SLOT_GAIN_BASE;
		else if (a == IA_MIN_VOLTAGE)
			d.slot = SLOT_MIN_VOLTAGE;
		else if (a == IA_LOOP_LOWER)
			d.slot = SLOT_LOOP_LOWER;
		else if (a >= IA_FSK_FIRST && a <= IA_FSK_LAST)
			d.slot = SLOT_W'(a - IA_FSK_FIRST) + SLOT_FSK_BASE;
		else
			d.mapped = 1'b0;
		return d;
	endfunction

endpackage

// *** core/ira_tick.sv ***
// periodic update tick generator
// assumes one free running clock; the tick is a one-cycle enable pulse
`timescale 1ns/1ps
module ira_tick #(
	parameter int TICK_CYCLES = ira_pkg::TICK_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// tick out
	output logic tick
);

	typedef struct packed {
		logic [15:0] count;
		logic tick;
	} ira_tick_state_type;

	ira_tick_state_type state_reg;
	ira_tick_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.count == 16'(TICK_CYCLES - 1))
		begin
			state_next.count = '0;
			state_next.tick = 1'b1;
		end
		else
			state_next.count = state_reg.count + 16'h0001;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign tick = state_reg.tick;

endmodule

// *** core/ira_irq.sv ***
// sticky event status with enable mask and write-one-to-clear
// assumes events are one-cycle pulses in the clock domain
`timescale 1ns/1ps
module ira_irq (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// events
	input wire logic [ira_pkg::EVT_W-1:0] event_set,
	// software access
	input wire logic enable_wr,
	input wire logic clear_wr,
	input wire logic [ira_pkg::EVT_W-1:0] wbits,
	// state out
	output logic [ira_pkg::EVT_W-1:0] status,
	output logic [ira_pkg::EVT_W-1:0] enable,
	output logic irq
);

	typedef struct packed {
		logic [ira_pkg::EVT_W-1:0] status;
		logic [ira_pkg::EVT_W-1:0] enable;
		logic irq;
	} ira_irq_state_type;

	ira_irq_state_type state_reg;
	ira_irq_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		if (enable_wr)
			state_next.enable = wbits;
		// a set in the clearing cycle survives
		state_next.status = (state_reg.status & ~(clear_wr ? wbits : ira_pkg::RST_EVT)) | event_set;
		state_next.irq = |(state_next.status & state_next.enable);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign status = state_reg.status;
	assign enable = state_reg.enable;
	assign irq = state_reg.irq;

endmodule

// *** core/ira_top.sv ***
// indirect register access unit: direct register port, request tracking,
// indirect word store and completion interrupt
// assumes a host that drives one-cycle strobes synchronous to clk
//
// Summary of operation
// R1: the indirect words have no direct address and are reached only through the data and address registers.
// R2: writing the data register and then the address register stores the data word at that indirect address on the next tick.
// R3: writing the address register with no data write before it loads that indirect word into the data register on the next tick.
// R4: pending transfers are serviced only on a 16 kHz tick derived from the clock.
// R5: the pending bit in register 31 stays one from the request until the tick that services it.
// R6: each completed transfer sets the done status bit in register 20, which raises the interrupt when enabled.
// R7: oscillator words sit at indirect 0 to 5, ringing at 6 to 9, receive gain at 13 and transmit gain at 14.
// R8: the renumbered map holds the upper loop threshold at 15, minimum voltage at 64, lower threshold at 66, FSK at 69 to 74.
// R9: every indirect word is 16 bits of two's complement and holds no defined value until written.
// R10: the host waits for the pending bit to drop or for the interrupt before the next request or readback.
`timescale 1ns/1ps
module ira_top #(
	parameter int TICK_CYCLES = ira_pkg::TICK_CYCLES
)(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [ira_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ira_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ira_pkg::DATA_W-1:0] reg_rdata,
	// interrupt
	output logic indirect_done_interrupt
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ira_pkg::DATA_W-1:0] indirect_data_reg;
		logic [ira_pkg::ADDR_W-1:0] indirect_address_reg;
		logic data_written;
		logic indirect_access_pending;
		logic is_write;
		logic [ira_pkg::EVT_W-1:0] events;
		logic [ira_pkg::DATA_W-1:0] rdata;
		logic [ira_pkg::SLOTS-1:0][ira_pkg::DATA_W-1:0] store;
	} ira_top_state_type;

	ira_top_state_type state_reg;
	ira_top_state_type state_next;

	ira_pkg::ira_bus_req_type req;
	ira_pkg::ira_decode_type target;
	logic tick;
	logic [ira_pkg::EVT_W-1:0] irq_status;
	logic [ira_pkg::EVT_W-1:0] irq_enable;
	logic enable_wr;
	logic clear_wr;
	logic data_wr;
	logic addr_wr;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	always_comb
	begin
		req.addr = reg_addr;
		req.wdata = reg_wdata;
		req.wr = reg_wr;
		req.rd = reg_rd;
	end

	assign data_wr = req.wr && req.addr == ira_pkg::OFS_INDIRECT_DATA;
	assign addr_wr = req.wr && req.addr == ira_pkg::OFS_INDIRECT_ADDRESS;
	assign enable_wr = req.wr && req.addr == ira_pkg::OFS_IRQ_ENABLE;
	assign clear_wr = req.wr && req.addr == ira_pkg::OFS_IRQ_CLEAR;

	// ----------------------------------------------------------------
	// update tick
	// ----------------------------------------------------------------
	ira_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.nrst(nrst),
		.tick(tick) // see R4
	);

	// ----------------------------------------------------------------
	// interrupt status, enable and clear
	// ----------------------------------------------------------------
	ira_irq u_irq (
		.clk(clk),
		.nrst(nrst),
		.event_set(state_reg.events), // see R6
		.enable_wr(enable_wr),
		.clear_wr(clear_wr),
		.wbits(req.wdata[ira_pkg::EVT_W-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(indirect_done_interrupt)
	);

	// ----------------------------------------------------------------
	// indirect address decoder
	// ----------------------------------------------------------------
	// the held address is decoded, so a read and a write see the same slot
	assign target = ira_pkg::ira_decode(state_reg.indirect_address_reg); // see R7 R8

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		state_next.events = ira_pkg::RST_EVT;
		state_next.rdata = '0;

		// host requests; a new one while a transfer is pending is dropped and flagged
		if (data_wr)
		begin
			if (state_reg.indirect_access_pending)
				state_next.events[ira_pkg::EVT_REFUSED] = 1'b1;
			else
			begin
				state_next.indirect_data_reg = req.wdata;
				state_next.data_written = 1'b1;
			end
		end

		if (addr_wr)
		begin
			if (state_reg.indirect_access_pending)
				state_next.events[ira_pkg::EVT_REFUSED] = 1'b1;
			else
			begin
				state_next.indirect_address_reg = req.wdata[ira_pkg::ADDR_W-1:0];
				state_next.indirect_access_pending = 1'b1; // see R5
				state_next.is_write = state_reg.data_written; // see R2 R3
				state_next.data_written = 1'b0;
			end
		end

		// service on the tick; the address write of this cycle waits for the next one
		if (tick && state_reg.indirect_access_pending)
		begin
			state_next.indirect_access_pending = 1'b0; // see R5
			state_next.events[ira_pkg::EVT_DONE] = 1'b1; // see R6
			if (!target.mapped)
				state_next.events[ira_pkg::EVT_UNMAPPED] = 1'b1;
			if (state_reg.is_write)
			begin
				if (target.mapped)
					state_next.store[target.slot] = state_reg.indirect_data_reg; // see R2 R9
			end
			else if (target.mapped)
				state_next.indirect_data_reg = state_reg.store[target.slot]; // see R3
			else
				state_next.indirect_data_reg = ira_pkg::RST_DATA;
		end

		// read data: the store itself has no direct offset
		if (req.rd)
		begin
			unique case (req.addr) // see R1
				ira_pkg::OFS_IRQ_STATUS:
					state_next.rdata = ira_pkg::DATA_W'(irq_status);
				ira_pkg::OFS_IRQ_ENABLE:
					state_next.rdata = ira_pkg::DATA_W'(irq_enable);
				ira_pkg::OFS_INDIRECT_DATA:
					state_next.rdata = state_reg.indirect_data_reg;
				ira_pkg::OFS_INDIRECT_ADDRESS:
					state_next.rdata = ira_pkg::DATA_W'(state_reg.indirect_address_reg);
				ira_pkg::OFS_ACCESS_STATUS:
				begin
					state_next.rdata[ira_pkg::STS_PENDING] = state_reg.indirect_access_pending;
					state_next.rdata[ira_pkg::STS_IS_WRITE] = state_reg.is_write;
					state_next.rdata[ira_pkg::STS_DATA_WRITTEN] = state_reg.data_written;
				end
				default:
					state_next.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// the store is cleared only to keep simulation free of unknowns;
	// software must not rely on its contents before writing them
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= '0;
			state_reg.indirect_data_reg <= ira_pkg::RST_DATA;
			state_reg.indirect_address_reg <= ira_pkg::RST_ADDR;
		end
		else
			state_reg <= state_next;
	end

	assign reg_rdata = state_reg.rdata;

endmodule

// *** testbench/ira_asserts.sv ***
// concurrent checks on the register port of the indirect access unit
// assumes one clock domain and a host that waits for idle between requests
`timescale 1ns/1ps
module ira_asserts #(
	parameter int TICK_CYCLES = 16
)(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// interrupt
	input wire logic indirect_done_interrupt
);
	logic wd, wa, we, wc, rs, re, rdd;
	assign wd = reg_wr && reg_addr == ira_pkg::OFS_INDIRECT_DATA;
	assign wa = reg_wr && reg_addr == ira_pkg::OFS_INDIRECT_ADDRESS;
	assign we = reg_wr && reg_addr == ira_pkg::OFS_IRQ_ENABLE;
	assign wc = reg_wr && reg_addr == ira_pkg::OFS_IRQ_CLEAR;
	assign rs = reg_rd && reg_addr == ira_pkg::OFS_ACCESS_STATUS;
	assign re = reg_rd && reg_addr == ira_pkg::OFS_IRQ_ENABLE;
	assign rdd = reg_rd && reg_addr == ira_pkg::OFS_INDIRECT_DATA;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// status read showing nothing pending, so the next request is accepted
	sequence free_s;
		rs ##1 !reg_rdata[0];
	endsequence
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	AST_UNMAPPED_ZERO: assert property (
		reg_rd && (reg_addr < 8'h14 || reg_addr > 8'h1F) |=> reg_rdata == 16'h0000)
		else $error("unmapped direct read not zero");
	AST_ENABLE_BACK: assert property (
		we ##1 re |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
		else $error("enable readback wrong");
	AST_DATA_BACK: assert property (
		free_s ##0 wd ##1 rdd |=> reg_rdata == $past(reg_wdata, 2))
		else $error("data register readback wrong");
	AST_WRITE_FLAGS: assert property (
		free_s ##0 wd ##1 wa ##1 rs |=> reg_rdata[1:0] == 2'b11)
		else $error("write request not pending");
	AST_PENDING_SET: assert property (free_s ##0 wa ##1 rs |=> reg_rdata[0])
		else $error("pending not set after request");
	AST_IRQ_MASKED: assert property (
		we && reg_wdata[2:0] == 3'h0 ##1 !we |=> !indirect_done_interrupt)
		else $error("interrupt high while disabled");
	AST_IRQ_FALL: assert property (
		$fell(indirect_done_interrupt) |-> $past(we || wc) || $past(we || wc, 2)
		|| $past(we || wc, 3))
		else $error("interrupt dropped without clear or mask");
endmodule
bind ira_top ira_asserts #(.TICK_CYCLES(TICK_CYCLES)) ira_asserts_i (.clk(clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .indirect_done_interrupt(indirect_done_interrupt));

// *** testbench/ira_host.sv ***
// host model driving the direct register port
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
module ira_host (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	logic rd_q = 1'b0;
	logic [15:0] last_rdata = 16'h0000;
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	always @(posedge clk)
		rd_q <= reg_rd;
	always @(negedge clk)
		if (rd_q)
			last_rdata <= reg_rdata;
	// one bus cycle: called on an edge, returns on the edge that samples it
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	// idle lines toggle so nothing leans on stale values
	task automatic idle();
		op(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
	endtask
	task automatic wait_idle(output int n);
		n = 0;
		do
		begin
			op(1'b0, 1'b1, ira_pkg::OFS_ACCESS_STATUS, 16'h0000);
			idle();
			n++;
		end
		while (last_rdata[0] && n < 64);
	endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the indirect access unit
// assumes the host model drives the register port
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, irq;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	logic [31:0] eq[$];
	logic [31:0] x;
	logic [7:0] amap[12] = '{8'h00, 8'h05, 8'h06, 8'h09, 8'h0D, 8'h0E, 8'h0F, 8'h1B, 8'h40,
		8'h42, 8'h45, 8'h4A};
	logic [7:0] umap[6] = '{8'h0A, 8'h0C, 8'h1C, 8'h3F, 8'h41, 8'h4B};
	initial
		forever #2.5 clk = ~clk;
	ira_top #(.TICK_CYCLES(16)) ira_top_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.indirect_done_interrupt(irq));
	ira_host ira_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ceiling well above the roughly 630 cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			mismatches++;
			stop_test();
		end
	end
	// answers are compared mid-cycle, away from the edge that launches them
	always @(negedge clk)
		if (ira_host_i.rd_q && eq.size() != 0)
		begin
			x = eq.pop_front();
			check(reg_rdata & x[31:16], x[15:0]);
		end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ira_host_i.op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		eq.push_back({m, e});
		ira_host_i.op(1'b0, 1'b1, a, 16'hFFFF);
	endtask
	task automatic irq_is(input logic e);
		ira_host_i.idle();
		ira_host_i.idle();
		@(negedge clk);
		check({15'h0000, irq}, {15'h0000, e});
		@(posedge clk);
	endtask
	task automatic put(input logic [7:0] a, input logic [15:0] d, input logic [15:0] st);
		ira_host_i.wait_idle(n);
		rd(8'h1F, 16'h0001, 16'h0000);
		wr(8'h1C, d);
		wr(8'h1D, {8'h00, a});
		rd(8'h1F, 16'h0003, 16'h0003);
		ira_host_i.wait_idle(n);
		// the tick phase against the request is free: a request that just misses
		// a tick waits a whole period, which takes up to nine status polls
		check({15'h0000, n >= 1 && n <= 9}, 16'h0001);
		irq_is(1'b1);
		rd(8'h14, 16'h0007, st);
		wr(8'h16, 16'h0007);
		irq_is(1'b0);
	endtask
	task automatic get(input logic [7:0] a, input logic [15:0] e, input logic ie);
		ira_host_i.wait_idle(n);
		rd(8'h1F, 16'h0001, 16'h0000);
		wr(8'h1D, {8'h00, a});
		rd(8'h1F, 16'h0003, 16'h0001);
		ira_host_i.wait_idle(n);
		rd(8'h1C, 16'hFFFF, e);
		irq_is(ie);
		if (ie)
			wr(8'h16, 16'h0007);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h14, 16'h0007, 16'h0000);
		rd(8'h00, 16'hFFFF, 16'h0000);
		rd(8'h40, 16'hFFFF, 16'h0000);
		wr(8'h14, 16'h0007);
		rd(8'h14, 16'h0007, 16'h0000);
		wr(8'h15, 16'h0007);
		rd(8'h15, 16'h0007, 16'h0007);
		$display("test registers done");
		foreach (amap[i])
			put(amap[i], {amap[i], ~amap[i]}, 16'h0001);
		foreach (amap[i])
			get(amap[i], {amap[i], ~amap[i]}, 1'b1);
		$display("test indirect map done");
		foreach (umap[i])
			put(umap[i], 16'h1234, 16'h0005);
		foreach (umap[i])
			get(umap[i], 16'h0000, 1'b1);
		$display("test unmapped done");
		ira_host_i.wait_idle(n);
		wr(8'h1D, 8'h0D);
		wr(8'h1C, 16'hDEAD);
		ira_host_i.wait_idle(n);
		rd(8'h1C, 16'hFFFF, 16'h0DF2);
		rd(8'h14, 16'h0007, 16'h0003);
		wr(8'h16, 16'h0007);
		wr(8'h15, 16'h0000);
		get(8'h0F, 16'h0FF0, 1'b0);
		wr(8'h15, 16'h0007);
		irq_is(1'b1);
		wr(8'h16, 16'h0007);
		irq_is(1'b0);
		$display("test refusal and mask done");
		rd(8'h1D, 16'hFFFF, 16'h000F);
		rd(8'h1F, 16'h0001, 16'h0000);
		wr(8'h1C, 16'h5A5A);
		rd(8'h1C, 16'hFFFF, 16'h5A5A);
		rd(8'h1F, 16'h0005, 16'h0004);
		$display("test readback done");
		stop_test();
	end
endmodule
